// ### rtl/dtm_pkg.sv
package dtm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int TS_W = 32;
    localparam int DIV_W = 24;

    // ------------------------------------------------------------
    // Profile layout: mode field in fourth byte
    // ------------------------------------------------------------
    localparam int MODE_BYTE = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;

    // Mode field encodings
    localparam logic [1:0] MODE_BUILDOUT = 2'h0;
    localparam logic [1:0] MODE_INT_ZD = 2'h1;
    localparam logic [1:0] MODE_NA = 2'h2;
    localparam logic [1:0] MODE_EXT_ZD = 2'h3;

    // Source codes treated as R = 1
    localparam logic [4:0] SRC_FB_DPLL0 = 5'h04;
    localparam logic [4:0] SRC_FB_DPLL1 = 5'h05;
    localparam logic [4:0] SRC_NCO0 = 5'h08;
    localparam logic [4:0] SRC_NCO1 = 5'h09;
    localparam logic [4:0] SRC_IUTS0 = 5'h0d;
    localparam logic [4:0] SRC_IUTS1 = 5'h0e;

    // Status bit positions
    localparam int STAT_EXIT_BIT = 3;
    localparam int STAT_ENTER_BIT = 4;

    // Reset values
    localparam logic [TS_W-1:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Profile fields used by this block
    typedef struct packed {
        logic [7:0] mode_byte;
        logic [4:0] source;
        logic [DIV_W-1:0] n_int;
        logic [DIV_W-1:0] n_frac;
        logic [DIV_W-1:0] feedback_modulus;
    } dtm_profile_s;

    // Divider settings outside the profile
    typedef struct packed {
        logic [DIV_W-1:0] r_div;
        logic [DIV_W-1:0] m_div;
        logic [DIV_W-1:0] q_div;
    } dtm_dividers_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEASURE,
        ST_HITLESS,
        ST_LOCKED
    } dtm_state_e;

endpackage

// ### rtl/dtm_mode_ctrl.sv
`timescale 1ns/1ns
module dtm_mode_ctrl #(
    parameter int TS_W = dtm_pkg::TS_W,
    parameter int DIV_W = dtm_pkg::DIV_W
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Active profile
    input wire dtm_pkg::dtm_profile_s profile_in,
    input wire logic profile_switch_in,
    input wire dtm_pkg::dtm_dividers_s dividers_in,
    // Acquisition control and time stamps
    input wire logic acquire_in,
    input wire logic ts_valid_in,
    input wire logic [TS_W-1:0] ref_ts_in,
    input wire logic [TS_W-1:0] fb_ts_in,
    input wire logic [TS_W-1:0] ref_period_in,
    // Slew limit, clamp and frequency offset
    input wire logic [TS_W-1:0] slew_limit_in,
    input wire logic [TS_W-1:0] clamp_in,
    input wire logic [TS_W-1:0] freq_offset_in,
    // Status clear
    input wire logic status_clr_in,
    input wire logic [7:0] status_clr_mask_in,
    // Results
    output logic [TS_W-1:0] buildout_offset_out,
    output logic [TS_W-1:0] freq_adjust_out,
    output logic hitless_out,
    output logic mode_na_out,
    output logic locked_out,
    output logic [7:0] status_out,
    output logic [2*DIV_W-1:0] ratio_num_out,
    output logic [2*DIV_W+1:0] ratio_den_out
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // Acquisition state
    dtm_pkg::dtm_state_e state_reg;
    dtm_pkg::dtm_state_e state_next;
    // Offset built into the feedback path
    logic [TS_W-1:0] buildout_offset_reg;
    // Residual phase error still to be steered out
    logic [TS_W-1:0] hitless_err_reg;
    logic [TS_W-1:0] hitless_err_next;
    // Steering word and sticky status
    logic [TS_W-1:0] freq_adjust_reg;
    logic [7:0] status_reg;
    // Hitless entry and exit strobes
    logic enter_ev;
    logic exit_ev;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Signed clamp to +/- limit
    function automatic logic [TS_W-1:0] sat(input logic [TS_W-1:0] v,
                                            input logic [TS_W-1:0] lim);
        logic signed [TS_W-1:0] s;
        logic signed [TS_W-1:0] l;
        s = $signed(v);
        l = $signed(lim);
        if (s > l) begin
            sat = lim;
        end else if (s < -l) begin
            sat = TS_W'(-l);
        end else begin
            sat = v;
        end
    endfunction

    // Fold an offset onto the nearest reference edge
    function automatic logic [TS_W-1:0] wrap_near(
        input logic [TS_W-1:0] err,
        input logic [TS_W-1:0] period
    );
        logic signed [TS_W-1:0] e;
        logic signed [TS_W-1:0] h;
        e = $signed(err);
        h = $signed(period >> 1);
        if (e > h) begin
            wrap_near = err - period;
        end else if (e < -h) begin
            wrap_near = err + period;
        end else begin
            wrap_near = err;
        end
    endfunction

    // Sources whose reference divider is bypassed
    function automatic logic unit_ratio_src(input logic [4:0] s);
        unit_ratio_src = (s == dtm_pkg::SRC_FB_DPLL0) ||
                         (s == dtm_pkg::SRC_FB_DPLL1) ||
                         (s == dtm_pkg::SRC_NCO0) ||
                         (s == dtm_pkg::SRC_NCO1) ||
                         (s == dtm_pkg::SRC_IUTS0) ||
                         (s == dtm_pkg::SRC_IUTS1);
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic [1:0] mode = profile_in.mode_byte[dtm_pkg::MODE_LSB +:
                                                 dtm_pkg::MODE_W];
    wire logic is_hitless = (mode == dtm_pkg::MODE_INT_ZD) ||
                            (mode == dtm_pkg::MODE_EXT_ZD);
    wire logic is_na = (mode == dtm_pkg::MODE_NA);
    wire logic unit_r = unit_ratio_src(profile_in.source);
    wire logic [DIV_W-1:0] r_eff = unit_r ? DIV_W'(1) : dividers_in.r_div;

    // Request and completion decode
    wire logic start_ok = acquire_in && !is_na;
    wire logic stamp_taken = (state_reg == dtm_pkg::ST_MEASURE) &&
                             ts_valid_in;
    wire logic err_settled = (hitless_err_reg == TS_W'(0));

    // Offset old vs new reference time stamp
    wire logic [TS_W-1:0] raw_err = ref_ts_in - fb_ts_in;
    // Nearest reference edge: wrap by one period
    wire logic [TS_W-1:0] near_err = wrap_near(raw_err, ref_period_in);

    // Phase-rate term limited in hitless, forced to zero in buildout
    wire logic [TS_W-1:0] slewed = is_hitless ?
        sat(hitless_err_reg, slew_limit_in) : TS_W'(0);
    wire logic [TS_W-1:0] total = sat(slewed + freq_offset_in,
                                      clamp_in);

    // Sticky status set and clear terms
    wire logic [7:0] status_set =
        (8'(enter_ev) << dtm_pkg::STAT_ENTER_BIT) |
        (8'(exit_ev) << dtm_pkg::STAT_EXIT_BIT);
    wire logic [7:0] status_clr = {8{status_clr_in}} & status_clr_mask_in;

    // Ratio terms, buildout form; high product bits beyond port width drop
    wire logic [2*DIV_W-1:0] num_full = (2*DIV_W)'((profile_in.n_int *
        profile_in.feedback_modulus + profile_in.n_frac) *
        dividers_in.m_div);
    wire logic [2*DIV_W+1:0] den_full = (2*DIV_W+2)'({r_eff, 1'b0} *
        dividers_in.q_div * profile_in.feedback_modulus);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        enter_ev = 1'b0;
        exit_ev = 1'b0;
        hitless_err_next = hitless_err_reg - slewed;
        unique case (state_reg)
            dtm_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_next = dtm_pkg::ST_MEASURE;
                end
            end
            dtm_pkg::ST_MEASURE: begin
                if (stamp_taken) begin
                    if (is_hitless) begin
                        state_next = dtm_pkg::ST_HITLESS;
                        enter_ev = 1'b1;
                        hitless_err_next = near_err;
                    end else begin
                        state_next = dtm_pkg::ST_LOCKED;
                    end
                end
            end
            dtm_pkg::ST_HITLESS: begin
                if (err_settled) begin
                    state_next = dtm_pkg::ST_LOCKED;
                    exit_ev = 1'b1;
                end
            end
            dtm_pkg::ST_LOCKED: begin
                if (start_ok) begin
                    state_next = dtm_pkg::ST_MEASURE;
                end
            end
        endcase
        // New profile: no error carried over from the old one
        if (profile_switch_in) begin
            state_next = dtm_pkg::ST_IDLE;
            hitless_err_next = dtm_pkg::OFFSET_RST;
            exit_ev = (state_reg == dtm_pkg::ST_HITLESS);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Acquisition state
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_reg <= dtm_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Residual phase error
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            hitless_err_reg <= dtm_pkg::OFFSET_RST;
        end else begin
            hitless_err_reg <= hitless_err_next;
        end
    end

    // Buildout offset captured at measurement
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in || profile_switch_in) begin
            buildout_offset_reg <= dtm_pkg::OFFSET_RST;
        end else if (stamp_taken) begin
            buildout_offset_reg <= raw_err;
        end
    end

    // Frequency steering output
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            freq_adjust_reg <= dtm_pkg::OFFSET_RST;
        end else begin
            freq_adjust_reg <= total;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            status_reg <= dtm_pkg::STATUS_RST;
        end else begin
            status_reg <= (status_reg & ~status_clr) | status_set;
        end
    end

    // Ratio numerator, (N*FEEDBACK_MODULUS+F)*M
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ratio_num_out <= '0;
        end else begin
            ratio_num_out <= num_full;
        end
    end

    // Ratio denominator, 2*R*Q*FEEDBACK_MODULUS
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ratio_den_out <= '0;
        end else begin
            ratio_den_out <= den_full;
        end
    end

    // Hitless flag
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            hitless_out <= 1'b0;
        end else begin
            hitless_out <= (state_next == dtm_pkg::ST_HITLESS);
        end
    end

    // Refused mode flag
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            mode_na_out <= 1'b0;
        end else begin
            mode_na_out <= is_na;
        end
    end

    // Locked flag
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            locked_out <= 1'b0;
        end else begin
            locked_out <= (state_next == dtm_pkg::ST_LOCKED);
        end
    end

    assign buildout_offset_out = buildout_offset_reg;
    assign freq_adjust_out = freq_adjust_reg;
    assign status_out = status_reg;

endmodule

// ### dv/dtm_mode_ctrl_monitor.sv
`timescale 1ns/1ns
module dtm_mode_ctrl_chk (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Watched inputs
    input wire dtm_pkg::dtm_profile_s profile_in,
    input wire logic profile_switch_in,
    input wire dtm_pkg::dtm_dividers_s dividers_in,
    input wire logic acquire_in,
    input wire logic ts_valid_in,
    input wire logic [31:0] ref_ts_in,
    input wire logic [31:0] fb_ts_in,
    input wire logic [31:0] clamp_in,
    input wire logic status_clr_in,
    input wire logic [7:0] status_clr_mask_in,
    // Watched outputs
    input wire logic [31:0] buildout_offset_out,
    input wire logic [31:0] freq_adjust_out,
    input wire logic hitless_out,
    input wire logic mode_na_out,
    input wire logic locked_out,
    input wire logic [7:0] status_out,
    input wire logic [49:0] ratio_den_out
);
    // ----
    // Helpers and properties
    // ----
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire [1:0] mode = profile_in.mode_byte[1:0];
    wire r_one = profile_in.source inside {5'h04, 5'h05, 5'h08, 5'h09,
                                           5'h0d, 5'h0e};
    wire [23:0] r_eff = r_one ? 24'h000001 : dividers_in.r_div;
    wire [73:0] den = 74'h2 * r_eff * dividers_in.q_div *
                      profile_in.feedback_modulus;
    mode_na_a: assert property ($past(rstn_in) |->
        mode_na_out == ($past(mode) == 2'h2)) else $error("na flag wrong");
    ratio_den_a: assert property ($past(rstn_in) && $stable(den) |->
        ratio_den_out == den[49:0]) else $error("denominator wrong");
    buildout_lock_a: assert property (acquire_in && mode == 2'h0 &&
        !hitless_out ##[1:4] ts_valid_in && !profile_switch_in |=> locked_out
        && !hitless_out && buildout_offset_out == $past(ref_ts_in - fb_ts_in))
        else $error("buildout lock wrong");
    hitless_enter_a: assert property (acquire_in && mode[0] &&
        !hitless_out ##[1:4] ts_valid_in && !profile_switch_in |=>
        hitless_out && status_out[4]) else $error("hitless entry wrong");
    enter_sticky_a: assert property (status_out[4] &&
        !(status_clr_in && status_clr_mask_in[4]) |=> status_out[4])
        else $error("enter bit lost");
    exit_latch_a: assert property ($fell(hitless_out) |->
        status_out[3]) else $error("exit bit missing");
    switch_clear_a: assert property (profile_switch_in |=>
        !hitless_out && !locked_out && buildout_offset_out == 32'h0)
        else $error("switch left state");
    clamp_bound_a: assert property ($signed(freq_adjust_out) <=
        $signed(clamp_in) && $signed(freq_adjust_out) >= -$signed(clamp_in))
        else $error("clamp exceeded");
    cover property (hitless_out ##1 locked_out);
    cover property (mode_na_out && acquire_in);
    cover property ($rose(locked_out) && !hitless_out);
endmodule
bind dtm_mode_ctrl dtm_mode_ctrl_chk chk_i (.ref_clk_in, .rstn_in,
    .profile_in, .profile_switch_in, .dividers_in, .acquire_in, .ts_valid_in,
    .ref_ts_in, .fb_ts_in, .clamp_in, .status_clr_in, .status_clr_mask_in,
    .buildout_offset_out, .freq_adjust_out, .hitless_out, .mode_na_out,
    .locked_out, .status_out, .ratio_den_out);

// ### dv/dtm_ref_src.sv
`timescale 1ns/1ns
module dtm_ref_src (
    // Clock and request
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [31:0] ref_val_in,
    input wire logic [31:0] fb_val_in,
    // Time stamps
    output logic ts_valid_out = 1'b0,
    output logic [31:0] ref_ts_out = 32'h0,
    output logic [31:0] fb_ts_out = 32'h0
);
    // One-cycle stamp pair; stale stamps toggle every cycle
    always_ff @(posedge clk_in) begin
        ts_valid_out <= fire_in;
        ref_ts_out <= fire_in ? ref_val_in : ~ref_ts_out;
        fb_ts_out <= fire_in ? fb_val_in : ~fb_ts_out;
    end
endmodule

// ### dv/dtm_mode_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) chk(64'(a), 64'(e))
module dtm_mode_ctrl_tb;
    // ----
    // Bench signals
    // ----
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    dtm_pkg::dtm_profile_s prof = '{8'h00, 5'h00, 24'h4, 24'h1, 24'h3};
    dtm_pkg::dtm_dividers_s divs = '{24'h5, 24'h2, 24'h2};
    logic sw = 1'b0, acq = 1'b0, fire = 1'b0, clr = 1'b0, tsv, hitl, na, lock;
    logic [7:0] clr_mask = 8'h00;
    logic [7:0] stat;
    logic [31:0] rv = 32'h0, fv = 32'h0, foff = 32'h3, rts, fts, offs, fadj;
    logic [47:0] num;
    logic [49:0] den;
    int fail_count = 0;
    int total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    dtm_mode_ctrl uut (.ref_clk_in(ref_clk), .rstn_in(rstn),
        .profile_in(prof), .profile_switch_in(sw), .dividers_in(divs),
        .acquire_in(acq), .ts_valid_in(tsv), .ref_ts_in(rts), .fb_ts_in(fts),
        .ref_period_in(32'h100), .slew_limit_in(32'h2), .clamp_in(32'h40),
        .freq_offset_in(foff), .status_clr_in(clr),
        .status_clr_mask_in(clr_mask), .buildout_offset_out(offs),
        .freq_adjust_out(fadj), .hitless_out(hitl), .mode_na_out(na),
        .locked_out(lock), .status_out(stat), .ratio_num_out(num),
        .ratio_den_out(den));
    dtm_ref_src src (.clk_in(ref_clk), .fire_in(fire), .ref_val_in(rv),
        .fb_val_in(fv), .ts_valid_out(tsv), .ref_ts_out(rts), .fb_ts_out(fts));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [63:0] a, input logic [63:0] e);
        total_checks++;
        if (a !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Switch profile mode, acquire, then stamp from the source
    task automatic acquire(input logic [1:0] m, input logic [31:0] r, f);
        @(posedge ref_clk);
        prof.mode_byte <= {6'h00, m};
        sw <= 1'b1;
        @(posedge ref_clk);
        {sw, acq, rv, fv} <= {1'b0, 1'b1, r, f};
        @(posedge ref_clk);
        {acq, fire} <= 2'b01;
        @(posedge ref_clk);
        fire <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic t_buildout();
        acquire(2'h0, 32'h100, 32'h40);
        `CHK({lock, hitl}, 2'b10);
        `CHK(offs, 32'hc0);
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(fadj, foff);
        `CHK(num, 48'h1a);
        `CHK(den, 50'h3c);
        $display("test buildout done");
    endtask
    task automatic t_rone();
        logic [4:0] srcs [7] = '{5'h04, 5'h05, 5'h08, 5'h09, 5'h0d, 5'h0e,
                                 5'h06};
        foreach (srcs[i]) begin
            @(posedge ref_clk);
            prof.source <= srcs[i];
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK(den, (i < 6) ? 50'hc : 50'h3c);
        end
        $display("test unit divider done");
    endtask
    task automatic t_hitless();
        logic [1:0] m [2] = '{2'h1, 2'h3};
        logic [31:0] fb [2] = '{32'hf8, 32'h1f8};
        logic [31:0] d [2];
        logic moved;
        foreach (m[i]) begin
            acquire(m[i], 32'h100, fb[i]);
            `CHK({hitl, stat[4]}, 2'b11);
            moved = 1'b0;
            for (int k = 0; k < 200 && lock !== 1'b1; k++) begin
                if (fadj !== foff && !moved) begin
                    d[i] = fadj - foff;
                    moved = 1'b1;
                end
                @(posedge ref_clk);
                #1;
            end
            `CHK(moved, 1'b1);
            `CHK({lock, hitl, stat[3]}, 3'b101);
            @(posedge ref_clk);
            {clr, clr_mask} <= {1'b1, 8'h18};
            @(posedge ref_clk);
            clr <= 1'b0;
            @(posedge ref_clk);
            #1;
            `CHK(stat, 8'h00);
        end
        `CHK(d[1], d[0]);
        `CHK(d[0] == 32'h2 || d[0] == 32'hffff_fffe, 1'b1);
        $display("test hitless done");
    endtask
    task automatic t_refuse();
        acquire(2'h2, 32'h100, 32'h40);
        `CHK({na, hitl, lock}, 3'b100);
        `CHK(offs, 32'h0);
        $display("test refuse done");
    endtask
    // ----
    // Sequence and watchdog
    // ----
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        t_buildout();
        t_rone();
        t_hitless();
        t_refuse();
        stop_test();
    end
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
endmodule
